// *** svd_pkg.sv ***
// Purpose: Shared constants and types for the supply level detector control block
// Assumes: AHB-Lite register bus, 32-bit data, 100 MHz system clock
// Notes: Register byte address is four times the register index

package svd_pkg;

    // ------------------------------------------------------------------
    // Clock and start-up timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    // Reference start-up interval in ns
    localparam int REF_STARTUP_NS = 25000;
    // Least time, so rounded up to whole cycles
    localparam int REF_STARTUP_CYC = (REF_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 12;
    localparam logic [CNT_W-1:0] STARTUP_LAST = CNT_W'(REF_STARTUP_CYC - 1);

    // ------------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_CTRL_STATUS = 8'h4a;
    localparam logic [7:0] IDX_LEVEL_SEL = 8'h4b;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h4c;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h4d;
    localparam logic [9:0] ADDR_CTRL_STATUS = {IDX_CTRL_STATUS, 2'b00};
    localparam logic [9:0] ADDR_LEVEL_SEL = {IDX_LEVEL_SEL, 2'b00};
    localparam logic [9:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
    localparam logic [9:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CS_ENABLE_BIT = 7;
    localparam int CS_OUT_BIT = 5;
    localparam int CS_READY_BIT = 4;
    localparam int CS_RISE_BIT = 1;
    localparam int CS_FALL_BIT = 0;
    localparam int LEVEL_W = 4;
    localparam int IRQ_TRIP_BIT = 0;
    localparam int IRQ_READY_BIT = 1;
    localparam int IRQ_W = 2;

    // ------------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------------
    localparam logic [LEVEL_W-1:0] LEVEL_RESET = 4'h0;
    localparam logic [LEVEL_W-1:0] LEVEL_RESERVED = 4'hf;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;
    localparam logic [CNT_W-1:0] CNT_RESET = 12'h000;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SVD_OFF = 3'b001,
        SVD_WARMUP = 3'b010,
        SVD_READY = 3'b100
    } svd_state_e;

    typedef enum logic [2:0] {
        SVD_SEL_NONE,
        SVD_SEL_CTRL,
        SVD_SEL_LEVEL,
        SVD_SEL_IRQ_STATUS,
        SVD_SEL_IRQ_MASK
    } svd_sel_e;

    typedef struct packed {
        svd_state_e state;
        logic [CNT_W-1:0] startup_cnt;
        logic enable;
        logic rise_en;
        logic fall_en;
        logic [LEVEL_W-1:0] level;
        logic [IRQ_W-1:0] irq_status;
        logic [IRQ_W-1:0] irq_mask;
        logic wr_pend;
        svd_sel_e wr_sel;
        logic [31:0] rdata;
        logic irq;
        logic wake;
        logic to_vector;
    } svd_regs_s;

endpackage

// *** svd_ctrl.sv ***
// Purpose: Control and status logic around a supply level detector comparator
// Assumes: Comparator result arrives synchronous to CLK_I; one AHB-Lite master
// Notes: Zero wait state slave; read data is captured in the address phase

`timescale 1ns/10ps
`default_nettype none

module svd_ctrl
    import svd_pkg::*;
(
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic POR_BOR_I,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic [31:0] HRDATA,
    output logic HRESP,
    // Analogue comparator side
    input wire logic SUPPLY_BELOW_I,
    output logic DETECT_ENABLE_O,
    output logic [LEVEL_W-1:0] LEVEL_SEL_O,
    // System power state
    input wire logic SLEEP_I,
    input wire logic GLOBAL_IE_I,
    output logic WAKE_O,
    output logic WAKE_TO_VECTOR_O,
    // Interrupt
    output logic IRQ_O
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------

    // Map a byte address onto a register select
    function automatic svd_sel_e decode_addr(input logic [31:0] addr);
        svd_sel_e sel;
        sel = SVD_SEL_NONE;
        if (addr[31:10] == 22'h000000)
        begin
            case (addr[9:0])
                ADDR_CTRL_STATUS: sel = SVD_SEL_CTRL;
                ADDR_LEVEL_SEL: sel = SVD_SEL_LEVEL;
                ADDR_IRQ_STATUS: sel = SVD_SEL_IRQ_STATUS;
                ADDR_IRQ_MASK: sel = SVD_SEL_IRQ_MASK;
                default: sel = SVD_SEL_NONE;
            endcase
        end
        return sel;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    svd_regs_s r_reg;
    svd_regs_s r_next;

    logic addr_take;
    logic wr_take;
    logic rd_take;
    svd_sel_e addr_sel;
    logic ready;
    logic trip_cond;
    logic trip_set;
    logic ready_set;
    logic [7:0] ctrl_view;

    // Bus request qualification
    assign addr_take = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
    assign wr_take = addr_take && HWRITE;
    assign rd_take = addr_take && !HWRITE;
    assign addr_sel = decode_addr(HADDR);

    // Detector ready once the start-up interval has run out
    assign ready = (r_reg.state == SVD_READY);

    // Trip condition from the enables, in every power mode
    // no mode gating
    assign trip_cond = (r_reg.rise_en && !SUPPLY_BELOW_I) ||
                       (r_reg.fall_en && SUPPLY_BELOW_I);

    assign trip_set = r_reg.enable && ready && trip_cond;

    // Ready event when start-up finishes
    assign ready_set = (r_reg.state == SVD_WARMUP) && (r_reg.startup_cnt == STARTUP_LAST);

    // Read view of the control and status register
    // comparator result
    assign ctrl_view = {r_reg.enable, 1'b0, SUPPLY_BELOW_I, ready,
                        2'b00, r_reg.rise_en, r_reg.fall_en};

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------

    // All block state computed here
    always_comb
    begin
        logic [IRQ_W-1:0] clr;
        logic [IRQ_W-1:0] set;
        clr = IRQ_RESET;
        set = IRQ_RESET;
        r_next = r_reg;

        // Data phase of a write lands in the selected register
        if (r_reg.wr_pend)
        begin
            case (r_reg.wr_sel)
                SVD_SEL_CTRL:
                begin
                    r_next.enable = HWDATA[CS_ENABLE_BIT];
                    r_next.rise_en = HWDATA[CS_RISE_BIT];
                    r_next.fall_en = HWDATA[CS_FALL_BIT];
                end
                SVD_SEL_LEVEL:
                begin
                    if (HWDATA[LEVEL_W-1:0] != LEVEL_RESERVED)
                    begin
                        r_next.level = HWDATA[LEVEL_W-1:0];
                    end
                end
                SVD_SEL_IRQ_STATUS:
                begin
                    clr = HWDATA[IRQ_W-1:0];
                end
                SVD_SEL_IRQ_MASK:
                begin
                    r_next.irq_mask = HWDATA[IRQ_W-1:0];
                end
                default:
                begin
                    r_next.irq_mask = r_reg.irq_mask;
                end
            endcase
        end

        // Address phase latched for the next cycle
        r_next.wr_pend = wr_take;
        r_next.wr_sel = addr_sel;

        // Read data captured at the address phase
        r_next.rdata = 32'h00000000;
        if (rd_take)
        begin
            case (addr_sel)
                SVD_SEL_CTRL: r_next.rdata = {24'h000000, ctrl_view};
                SVD_SEL_LEVEL: r_next.rdata = {28'h0000000, r_reg.level};
                SVD_SEL_IRQ_STATUS: r_next.rdata = {30'h00000000, r_reg.irq_status};
                SVD_SEL_IRQ_MASK: r_next.rdata = {30'h00000000, r_reg.irq_mask};
                default: r_next.rdata = 32'h00000000;
            endcase
        end

        // Reference start-up sequencing
        // fixed cycle count
        r_next.startup_cnt = CNT_RESET;
        case (r_reg.state)
            SVD_OFF:
            begin
                if (r_reg.enable)
                begin
                    r_next.state = SVD_WARMUP;
                end
            end
            SVD_WARMUP:
            begin
                r_next.startup_cnt = r_reg.startup_cnt + 12'h001;
                if (!r_reg.enable)
                begin
                    r_next.state = SVD_OFF;
                end
                else if (ready_set)
                begin
                    r_next.state = SVD_READY;
                end
            end
            SVD_READY:
            begin
                if (!r_reg.enable)
                begin
                    r_next.state = SVD_OFF;
                end
            end
            default:
            begin
                r_next.state = SVD_OFF;
            end
        endcase

        // Sticky flags, set wins over clear
        // sticky set priority
        set[IRQ_TRIP_BIT] = trip_set;
        set[IRQ_READY_BIT] = ready_set && r_reg.enable;
        r_next.irq_status = (r_reg.irq_status & ~clr) | set;

        // Level interrupt from unmasked flags
        r_next.irq = |(r_next.irq_status & r_next.irq_mask);

        // Wake from sleep on a trip, with the resume target
        // sleep wake
        r_next.wake = SLEEP_I && trip_set;
        r_next.to_vector = (SLEEP_I && trip_set) ? GLOBAL_IE_I : r_reg.to_vector;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------

    // Synchronous reset of all state except level, which resets only with POR_BOR_I
    always_ff @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            r_reg.state <= SVD_OFF;
            r_reg.startup_cnt <= CNT_RESET;
            r_reg.enable <= 1'b0;
            r_reg.rise_en <= 1'b0;
            r_reg.fall_en <= 1'b0;
            r_reg.irq_status <= IRQ_RESET;
            r_reg.irq_mask <= IRQ_RESET;
            r_reg.wr_pend <= 1'b0;
            r_reg.wr_sel <= SVD_SEL_NONE;
            r_reg.rdata <= 32'h00000000;
            r_reg.irq <= 1'b0;
            r_reg.wake <= 1'b0;
            r_reg.to_vector <= 1'b0;
            if (POR_BOR_I)
            begin
                r_reg.level <= LEVEL_RESET;
            end
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------

    // Outputs taken straight from flip-flops or tied to constants
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign HRDATA = r_reg.rdata;
    assign DETECT_ENABLE_O = r_reg.enable;
    assign LEVEL_SEL_O = r_reg.level;
    assign WAKE_O = r_reg.wake;
    assign WAKE_TO_VECTOR_O = r_reg.to_vector;
    assign IRQ_O = r_reg.irq;

endmodule

`default_nettype wire

// *** svd_ctrl_sva.sv ***
// Purpose: Port assertions for the supply level detector control block
// Assumes: One clock domain, synchronous active-high reset
// Notes: Bound to svd_ctrl below the module
`timescale 1ns/10ps
`default_nettype none
module svd_ctrl_sva
    import svd_pkg::*;
(
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic POR_BOR_I,
    // Bus request
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HWDATA,
    // Detector and power state
    input wire logic SLEEP_I,
    input wire logic GLOBAL_IE_I,
    input wire logic DETECT_ENABLE_O,
    input wire logic [LEVEL_W-1:0] LEVEL_SEL_O,
    input wire logic WAKE_O,
    input wire logic WAKE_TO_VECTOR_O,
    input wire logic IRQ_O
);
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    int on_cnt_reg;
    wire logic ctrl_wr = HSEL && HTRANS == HTRANS_NONSEQ && HWRITE && HADDR[9:0] == ADDR_CTRL_STATUS;

    // Cycles spent enabled
    always_ff @(posedge CLK_I)
    begin
        on_cnt_reg <= (RST_I || !DETECT_ENABLE_O) ? 0 : on_cnt_reg + 1;
    end

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_reset_all_off: assert property (disable iff (1'b0)
        RST_I |=> !DETECT_ENABLE_O && !IRQ_O && !WAKE_O) else $error("outputs live after reset");
    a_por_level_zero: assert property (disable iff (1'b0)
        RST_I && POR_BOR_I |=> LEVEL_SEL_O == LEVEL_RESET) else $error("level not cleared");
    a_plain_reset_keep: assert property (disable iff (1'b0)
        RST_I && !POR_BOR_I |=> $stable(LEVEL_SEL_O)) else $error("level lost on reset");
    a_level_no_reserved: assert property (
        LEVEL_SEL_O != LEVEL_RESERVED) else $error("reserved level code taken");
    a_enable_write: assert property (
        ctrl_wr ##1 1'b1 |=> DETECT_ENABLE_O == $past(HWDATA[CS_ENABLE_BIT]))
        else $error("enable bit not written");
    a_trip_after_warmup: assert property (
        $rose(IRQ_O) && DETECT_ENABLE_O |-> on_cnt_reg >= REF_STARTUP_CYC)
        else $error("trip before start-up ended");
    a_wake_in_sleep: assert property (
        WAKE_O |-> $past(SLEEP_I) && $past(DETECT_ENABLE_O)) else $error("wake without sleep");
    a_wake_vector: assert property (
        WAKE_O |-> WAKE_TO_VECTOR_O == $past(GLOBAL_IE_I)) else $error("wake target wrong");
endmodule

bind svd_ctrl svd_ctrl_sva u_svd_sva
(
    .CLK_I, .RST_I, .POR_BOR_I, .HSEL, .HADDR, .HTRANS, .HWRITE, .HWDATA, .SLEEP_I,
    .GLOBAL_IE_I, .DETECT_ENABLE_O, .LEVEL_SEL_O, .WAKE_O, .WAKE_TO_VECTOR_O, .IRQ_O
);
`default_nettype wire

// *** tb_supply_voltage_detect_ctrl.sv ***
// Purpose: Self-checking bench for the supply level detector control block
// Assumes: Zero wait slave; start-up of 2500 cycles
// Notes: Bench drives every input port itself except HSIZE, tied to 3'h2, and HREADY, which is looped back from HREADYOUT
`timescale 1ns/10ps
`default_nettype none
module tb_supply_voltage_detect_ctrl import svd_pkg::*;;
    logic CLK_I = 1'b0;
    logic RST_I = 1'b1;
    logic POR_BOR_I = 1'b1;
    logic HSEL = 1'b0;
    logic [31:0] HADDR = 32'h0;
    logic [1:0] HTRANS = 2'h0;
    logic HWRITE = 1'b0;
    logic [31:0] HWDATA = 32'h0;
    logic SUPPLY_BELOW_I = 1'b0;
    logic SLEEP_I = 1'b0;
    logic GLOBAL_IE_I = 1'b0;
    logic HREADYOUT, HRESP, DETECT_ENABLE_O, WAKE_O, WAKE_TO_VECTOR_O, IRQ_O;
    logic [31:0] HRDATA;
    logic [LEVEL_W-1:0] LEVEL_SEL_O;
    int num_errors = 0;
    int total_checks = 0;

    svd_ctrl dut (.CLK_I(CLK_I), .RST_I(RST_I), .POR_BOR_I(POR_BOR_I), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP),
        .SUPPLY_BELOW_I(SUPPLY_BELOW_I), .DETECT_ENABLE_O(DETECT_ENABLE_O),
        .LEVEL_SEL_O(LEVEL_SEL_O), .SLEEP_I(SLEEP_I), .GLOBAL_IE_I(GLOBAL_IE_I),
        .WAKE_O(WAKE_O), .WAKE_TO_VECTOR_O(WAKE_TO_VECTOR_O), .IRQ_O(IRQ_O));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One single transfer, address phase then data phase
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge CLK_I);
        HSEL <= 1'b1;
        HTRANS <= HTRANS_NONSEQ;
        HADDR <= {22'h0, a};
        HWRITE <= w;
        do @(posedge CLK_I); while (HREADYOUT !== 1'b1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge CLK_I); while (HREADYOUT !== 1'b1);
        q = HRDATA;
        check(32'(HRESP), 32'h0);
    endtask

    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [9:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, exp);
    endtask

    task automatic wait_wake(input logic vec);
        int n;
        n = 0;
        while (WAKE_O !== 1'b1 && n < 50)
        begin
            @(posedge CLK_I);
            n++;
        end
        check(32'(WAKE_O), 32'h1);
        check(32'(WAKE_TO_VECTOR_O), 32'(vec));
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_and_levels();
        rd(ADDR_CTRL_STATUS, 32'h0);
        rd(ADDR_LEVEL_SEL, 32'h0);
        rd(10'h200, 32'h0);
        rd(ADDR_IRQ_STATUS, 32'h0);
        for (int i = 0; i < 15; i++)
        begin
            wr(ADDR_LEVEL_SEL, 32'(i));
            rd(ADDR_LEVEL_SEL, 32'(i));
        end
        wr(ADDR_LEVEL_SEL, 32'hf);
        rd(ADDR_LEVEL_SEL, 32'he);
        SUPPLY_BELOW_I <= 1'b1;
        rd(ADDR_CTRL_STATUS, 32'h20);
    endtask

    task automatic t_fall_trip();
        wr(ADDR_IRQ_MASK, 32'h1);
        wr(ADDR_CTRL_STATUS, 32'h81);
        repeat (2480) @(posedge CLK_I);
        check(32'(DETECT_ENABLE_O), 32'h1);
        rd(ADDR_CTRL_STATUS, 32'ha1);
        rd(ADDR_IRQ_STATUS, 32'h0);
        repeat (40) @(posedge CLK_I);
        rd(ADDR_CTRL_STATUS, 32'hb1);
        rd(ADDR_IRQ_STATUS, 32'h3);
        check(32'(IRQ_O), 32'h1);
        wr(ADDR_IRQ_STATUS, 32'h3);
        rd(ADDR_IRQ_STATUS, 32'h1);
        SUPPLY_BELOW_I <= 1'b0;
        wr(ADDR_IRQ_STATUS, 32'h1);
        rd(ADDR_IRQ_STATUS, 32'h0);
        check(32'(IRQ_O), 32'h0);
        SUPPLY_BELOW_I <= 1'b1;
        @(posedge CLK_I);
        SUPPLY_BELOW_I <= 1'b0;
        rd(ADDR_IRQ_STATUS, 32'h1);
    endtask

    task automatic t_rise_sleep();
        wr(ADDR_CTRL_STATUS, 32'h0);
        SUPPLY_BELOW_I <= 1'b1;
        wr(ADDR_CTRL_STATUS, 32'h82);
        repeat (2520) @(posedge CLK_I);
        wr(ADDR_IRQ_STATUS, 32'h3);
        rd(ADDR_IRQ_STATUS, 32'h0);
        SUPPLY_BELOW_I <= 1'b0;
        SLEEP_I <= 1'b1;
        GLOBAL_IE_I <= 1'b1;
        wait_wake(1'b1);
        rd(ADDR_IRQ_STATUS, 32'h1);
        SLEEP_I <= 1'b0;
        SUPPLY_BELOW_I <= 1'b1;
        wr(ADDR_IRQ_STATUS, 32'h1);
        SUPPLY_BELOW_I <= 1'b0;
        SLEEP_I <= 1'b1;
        GLOBAL_IE_I <= 1'b0;
        wait_wake(1'b0);
        SLEEP_I <= 1'b0;
    endtask

    task automatic t_plain_reset();
        wr(ADDR_CTRL_STATUS, 32'h0);
        wr(ADDR_LEVEL_SEL, 32'h9);
        wr(ADDR_CTRL_STATUS, 32'h83);
        repeat (2520) @(posedge CLK_I);
        wr(ADDR_IRQ_STATUS, 32'h3);
        rd(ADDR_IRQ_STATUS, 32'h1);
        SUPPLY_BELOW_I <= 1'b1;
        wr(ADDR_IRQ_STATUS, 32'h1);
        rd(ADDR_IRQ_STATUS, 32'h1);
        check(32'(LEVEL_SEL_O), 32'h9);
        RST_I <= 1'b1;
        SUPPLY_BELOW_I <= 1'b0;
        repeat (2) @(posedge CLK_I);
        RST_I <= 1'b0;
        rd(ADDR_LEVEL_SEL, 32'h9);
        check(32'(LEVEL_SEL_O), 32'h9);
        rd(ADDR_CTRL_STATUS, 32'h0);
        check(32'(DETECT_ENABLE_O), 32'h0);
        check(32'(IRQ_O), 32'h0);
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Clock and hang guard
    initial
    begin
        forever #5 CLK_I = ~CLK_I;
    end

    initial
    begin
        repeat (20000) @(posedge CLK_I);
        num_errors++;
        tally_and_finish();
    end

    // Main sequence
    initial
    begin
        repeat (6) @(posedge CLK_I);
        RST_I <= 1'b0;
        POR_BOR_I <= 1'b0;
        t_reset_and_levels();
        t_fall_trip();
        t_rise_sleep();
        t_plain_reset();
        tally_and_finish();
    end
endmodule
`default_nettype wire
